// ===== dac_control_register_bank.sv
/*
 * control and status register bank of the interpolating converter.
 * register map (offset, name, host access):
 *   0x0  lock_and_id_status             read only, live lock levels and codes
 *   0x1  delay_filter_selftest_control  read/write, bit 5 unused
 *   0x2  format_and_filter_mode         read/write
 *   0x3  error_mask_and_soft_sync       read/write
 *   0x4  error_flags                    set by hardware, a written zero clears
 *   0x5  interface_and_bypass_control   read/write
 *   0x6  sleep_and_bias_control         read/write
 *   0x7  output_gain                    read/write
 *   0x8  align_loop_restart             read/write
 *   0x9  synth_divider_setting          read/write
 *   0xA  align_loop_tuning              read/write
 *   0xB  synth_loop_tuning              read/write
 *   0xC  output_offset_high             read/write
 *   0xD  output_offset_low              read/write
 *   0xE  serial_out_function_select     read/write
 *   0xF  spare_reserved                 reads zero, writes ignored
 * assumes requests arrive from the serial control port already decoded into
 * one-cycle read or write strobes synchronous to core_clk_i.
 */
//
// Contract
// - status bit7 reads synthesizer lock
// - status bit6 reads alignment loop lock
// - fixed three-bit part code, write protected
// - hardwired two-bit register set revision
// - two-bit output delay, zero to three
// - filter enable routes through interpolation, reset one
// - self-test enable runs core self-test
// - signed three-bit pointer offset field
// - offset reloaded on each sync event unless sync-disable is set
// - sync-disable bit blocks offset reload
// - self-test fail flag set, cleared by zero
module dac_control_register_bank #(
    parameter logic [2:0] PART_CODE = 3'h5,  // arbitrary value
    parameter logic [1:0] REV_CODE  = 2'h0   // arbitrary value
) (
    input  wire logic                       core_clk_i,
    input  wire logic                       rstn_i,
    input  wire dac_regs_pkg::reg_req_t     req_i,
    output logic [7:0]                      rdata_o,
    output logic                            rvalid_o,
    input  wire dac_regs_pkg::core_status_t status_i,
    output dac_regs_pkg::core_ctrl_t        ctrl_o
);

    typedef struct packed {
        logic [15:0][7:0] regs;
        logic [7:0]       rdata;
        logic             rvalid;
        logic             load;
    } state_t;

    state_t st;
    state_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // access attributes of one register
    typedef struct packed {
        logic [7:0] wmask;
        logic [7:0] rmask;
        logic       clear_on_zero;
        logic       live_status;
    } reg_attr_t;

    ////////////////////////////////////////////////////////////////////////////
    // per-register write mask, read mask and kind
    function automatic reg_attr_t reg_attr(input logic [3:0] a);
        reg_attr_t attr;
        attr.wmask         = 8'hFF;
        attr.rmask         = 8'hFF;
        attr.clear_on_zero = 1'b0;
        attr.live_status   = 1'b0;
        case (a)
            dac_regs_pkg::OFS_LOCK_AND_ID_STATUS: begin
                attr.wmask         = 8'h00;
                attr.rmask         = 8'h00;
                attr.clear_on_zero = 1'b0;
                attr.live_status   = 1'b1;
            end
            dac_regs_pkg::OFS_DELAY_FILTER_SELFTEST_CONTROL: begin
                attr.wmask         = dac_regs_pkg::WMASK_CTRL1;
                attr.rmask         = dac_regs_pkg::WMASK_CTRL1;
                attr.clear_on_zero = 1'b0;
                attr.live_status   = 1'b0;
            end
            dac_regs_pkg::OFS_FORMAT_AND_FILTER_MODE: begin
                attr.wmask         = 8'hFF;
                attr.rmask         = 8'hFF;
                attr.clear_on_zero = 1'b0;
                attr.live_status   = 1'b0;
            end
            dac_regs_pkg::OFS_ERROR_MASK_AND_SOFT_SYNC: begin
                attr.wmask         = 8'hFF;
                attr.rmask         = 8'hFF;
                attr.clear_on_zero = 1'b0;
                attr.live_status   = 1'b0;
            end
            dac_regs_pkg::OFS_ERROR_FLAGS: begin
                attr.wmask         = dac_regs_pkg::WMASK_FLAGS;
                attr.rmask         = dac_regs_pkg::WMASK_FLAGS;
                attr.clear_on_zero = 1'b1;
                attr.live_status   = 1'b0;
            end
            dac_regs_pkg::OFS_INTERFACE_AND_BYPASS_CONTROL: begin
                attr.wmask         = 8'hFF;
                attr.rmask         = 8'hFF;
                attr.clear_on_zero = 1'b0;
                attr.live_status   = 1'b0;
            end
            dac_regs_pkg::OFS_SLEEP_AND_BIAS_CONTROL: begin
                attr.wmask         = 8'hFF;
                attr.rmask         = 8'hFF;
                attr.clear_on_zero = 1'b0;
                attr.live_status   = 1'b0;
            end
            dac_regs_pkg::OFS_OUTPUT_GAIN: begin
                attr.wmask         = 8'hFF;
                attr.rmask         = 8'hFF;
                attr.clear_on_zero = 1'b0;
                attr.live_status   = 1'b0;
            end
            dac_regs_pkg::OFS_ALIGN_LOOP_RESTART: begin
                attr.wmask         = 8'hFF;
                attr.rmask         = 8'hFF;
                attr.clear_on_zero = 1'b0;
                attr.live_status   = 1'b0;
            end
            dac_regs_pkg::OFS_SYNTH_DIVIDER_SETTING: begin
                attr.wmask         = 8'hFF;
                attr.rmask         = 8'hFF;
                attr.clear_on_zero = 1'b0;
                attr.live_status   = 1'b0;
            end
            dac_regs_pkg::OFS_ALIGN_LOOP_TUNING: begin
                attr.wmask         = 8'hFF;
                attr.rmask         = 8'hFF;
                attr.clear_on_zero = 1'b0;
                attr.live_status   = 1'b0;
            end
            dac_regs_pkg::OFS_SYNTH_LOOP_TUNING: begin
                attr.wmask         = 8'hFF;
                attr.rmask         = 8'hFF;
                attr.clear_on_zero = 1'b0;
                attr.live_status   = 1'b0;
            end
            dac_regs_pkg::OFS_OUTPUT_OFFSET_HIGH: begin
                attr.wmask         = 8'hFF;
                attr.rmask         = 8'hFF;
                attr.clear_on_zero = 1'b0;
                attr.live_status   = 1'b0;
            end
            dac_regs_pkg::OFS_OUTPUT_OFFSET_LOW: begin
                attr.wmask         = 8'hFF;
                attr.rmask         = 8'hFF;
                attr.clear_on_zero = 1'b0;
                attr.live_status   = 1'b0;
            end
            dac_regs_pkg::OFS_SERIAL_OUT_FUNCTION_SELECT: begin
                attr.wmask         = 8'hFF;
                attr.rmask         = 8'hFF;
                attr.clear_on_zero = 1'b0;
                attr.live_status   = 1'b0;
            end
            dac_regs_pkg::OFS_SPARE_RESERVED: begin
                attr.wmask         = 8'h00;
                attr.rmask         = 8'h00;
                attr.clear_on_zero = 1'b0;
                attr.live_status   = 1'b0;
            end
            default: begin
                attr.wmask         = 8'hFF;
                attr.rmask         = 8'hFF;
                attr.clear_on_zero = 1'b0;
                attr.live_status   = 1'b0;
            end
        endcase
        return attr;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // live view of the status register
    function automatic logic [7:0] status_view(input dac_regs_pkg::core_status_t c);
        logic [7:0] v;
        v = 8'h00;
        v[dac_regs_pkg::POS_SYNTH_LOCK] = c.synth_lock;
        v[dac_regs_pkg::POS_ALIGN_LOCK] = c.align_lock;
        v[dac_regs_pkg::POS_PART_CODE_LO +: 3] = PART_CODE;
        v[dac_regs_pkg::POS_REV_LO +: 2] = REV_CODE;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // read view of one register
    function automatic logic [7:0] read_view(input state_t s, input logic [3:0] a,
                                             input dac_regs_pkg::core_status_t c);
        logic [7:0] v;
        reg_attr_t  t;
        t = reg_attr(a);
        v = s.regs[a] & t.rmask;
        if (t.live_status) begin
            v = status_view(c);
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // plain masked write
    function automatic logic [7:0] masked_write(input logic [7:0] old, input logic [7:0] wdata,
                                                input logic [7:0] wm);
        return (old & ~wm) | (wdata & wm);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // clear-only write: a written one keeps the flag
    function automatic logic [7:0] flag_write(input logic [7:0] old, input logic [7:0] wdata,
                                              input logic [7:0] wm);
        return old & (wdata | ~wm);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // hardware error sources into flag positions
    function automatic logic [7:0] flag_sources(input dac_regs_pkg::core_status_t c);
        logic [7:0] v;
        v = 8'h00;
        v[dac_regs_pkg::POS_SELFTEST_FAIL] = c.selftest_fail;
        v[dac_regs_pkg::POS_FIFO_FAIL] = c.fifo_fail;
        v[dac_regs_pkg::POS_PATTERN_FAIL] = c.pattern_fail;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // offset reload decision for a sync event
    function automatic logic sync_reload(input state_t s,
                                         input dac_regs_pkg::core_status_t c);
        logic go;
        go = 1'b0;
        if (c.sync_event) begin
            go = ~s.regs[dac_regs_pkg::OFS_INTERFACE_AND_BYPASS_CONTROL][dac_regs_pkg::POS_OFFSET_SYNC_DISABLE];
        end
        return go;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // core control outputs from the stored registers
    function automatic dac_regs_pkg::core_ctrl_t ctrl_view(input state_t s);
        dac_regs_pkg::core_ctrl_t c;
        logic [7:0]               r;
        r = s.regs[dac_regs_pkg::OFS_DELAY_FILTER_SELFTEST_CONTROL];
        c.out_delay            = r[dac_regs_pkg::POS_OUT_DELAY_LO +: 2];
        c.filter_enable        = r[dac_regs_pkg::POS_FILTER_ENABLE];
        c.core_selftest_enable = r[dac_regs_pkg::POS_SELFTEST_ENABLE];
        c.ptr_offset           = r[dac_regs_pkg::POS_PTR_OFFSET_LO +: 3];
        c.ptr_offset_load      = s.load;
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        reg_attr_t  attr;
        logic [7:0] flags;
        logic [3:0] a;
        a = req_i.addr;
        attr = reg_attr(req_i.addr);
        flags = flag_sources(status_i);
        next_st = st;
        // read answer, one cycle after the strobe
        next_st.rvalid = req_i.rd_en;
        if (req_i.rd_en) begin
            next_st.rdata = read_view(st, a, status_i);
        end
        // host write, masked per register
        if (req_i.wr_en) begin
            if (attr.clear_on_zero) begin
                next_st.regs[a] = flag_write(st.regs[a], req_i.wdata, attr.wmask);
            end else begin
                next_st.regs[a] = masked_write(st.regs[a], req_i.wdata, attr.wmask);
            end
        end
        // hardware set wins over a clearing write
        next_st.regs[dac_regs_pkg::OFS_ERROR_FLAGS] =
            next_st.regs[dac_regs_pkg::OFS_ERROR_FLAGS] | flags;
        // the status register is never stored
        next_st.regs[dac_regs_pkg::OFS_LOCK_AND_ID_STATUS] = 8'h00;
        // offset reload on sync unless disabled
        next_st.load = sync_reload(st, status_i);
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 16; i++) begin
                st.regs[i] <= dac_regs_pkg::RESET_VALUES[i];
            end
            st.rdata <= 8'h00;
            st.rvalid <= 1'b0;
            st.load <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs to the host (read data, valid) and the converter core (control)
    assign rdata_o  = st.rdata;
    assign rvalid_o = st.rvalid;
    assign ctrl_o   = ctrl_view(st);

endmodule

// ===== dac_regs_pkg.sv
/*
 * shared constants and carrier types for the converter control register bank.
 * assumes a single core clock domain and a byte-wide register access port.
 */
package dac_regs_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_REGS = 16;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [3:0] OFS_LOCK_AND_ID_STATUS = 4'h0;
    localparam logic [3:0] OFS_DELAY_FILTER_SELFTEST_CONTROL = 4'h1;
    localparam logic [3:0] OFS_FORMAT_AND_FILTER_MODE = 4'h2;
    localparam logic [3:0] OFS_ERROR_MASK_AND_SOFT_SYNC = 4'h3;
    localparam logic [3:0] OFS_ERROR_FLAGS = 4'h4;
    localparam logic [3:0] OFS_INTERFACE_AND_BYPASS_CONTROL = 4'h5;
    localparam logic [3:0] OFS_SLEEP_AND_BIAS_CONTROL = 4'h6;
    localparam logic [3:0] OFS_OUTPUT_GAIN = 4'h7;
    localparam logic [3:0] OFS_ALIGN_LOOP_RESTART = 4'h8;
    localparam logic [3:0] OFS_SYNTH_DIVIDER_SETTING = 4'h9;
    localparam logic [3:0] OFS_ALIGN_LOOP_TUNING = 4'hA;
    localparam logic [3:0] OFS_SYNTH_LOOP_TUNING = 4'hB;
    localparam logic [3:0] OFS_OUTPUT_OFFSET_HIGH = 4'hC;
    localparam logic [3:0] OFS_OUTPUT_OFFSET_LOW = 4'hD;
    localparam logic [3:0] OFS_SERIAL_OUT_FUNCTION_SELECT = 4'hE;
    localparam logic [3:0] OFS_SPARE_RESERVED = 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned POS_SYNTH_LOCK = 7;
    localparam int unsigned POS_ALIGN_LOCK = 6;
    localparam int unsigned POS_PART_CODE_LO = 2;
    localparam int unsigned POS_REV_LO = 0;
    localparam int unsigned POS_OUT_DELAY_LO = 6;
    localparam int unsigned POS_FILTER_ENABLE = 4;
    localparam int unsigned POS_SELFTEST_ENABLE = 3;
    localparam int unsigned POS_PTR_OFFSET_LO = 0;
    localparam int unsigned POS_SELFTEST_FAIL = 6;
    localparam int unsigned POS_FIFO_FAIL = 5;
    localparam int unsigned POS_PATTERN_FAIL = 4;
    localparam int unsigned POS_OFFSET_SYNC_DISABLE = 4;

    ////////////////////////////////////////////////////////////////////////////
    // writable-bit masks (zero bits keep their hardware value)
    localparam logic [7:0] WMASK_CTRL1 = 8'hDF;
    localparam logic [7:0] WMASK_FLAGS = 8'h70;

    ////////////////////////////////////////////////////////////////////////////
    // reset values, index = offset
    localparam logic [7:0] RESET_VALUES [16] = '{
        8'h00, 8'h10, 8'hC0, 8'h70, 8'h00, 8'h00, 8'h0C, 8'hFF,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
    };

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [3:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       synth_lock;
        logic       align_lock;
        logic       sync_event;
        logic       selftest_fail;
        logic       fifo_fail;
        logic       pattern_fail;
    } core_status_t;

    typedef struct packed {
        logic [1:0] out_delay;
        logic       filter_enable;
        logic       core_selftest_enable;
        logic [2:0] ptr_offset;
        logic       ptr_offset_load;
    } core_ctrl_t;

endpackage

// ===== dac_regs_props.sv
/* checker: port relations of the register bank.
   assumes bind onto the bank, one clock, async low reset. */
module dac_regs_props #(
    parameter logic [2:0] PART_CODE = 3'h5,
    parameter logic [1:0] REV_CODE  = 2'h0
) (
    input wire logic                       core_clk_i,
    input wire logic                       rstn_i,
    input wire dac_regs_pkg::reg_req_t     req_i,
    input wire logic [7:0]                 rdata_o,
    input wire logic                       rvalid_o,
    input wire dac_regs_pkg::core_status_t status_i,
    input wire dac_regs_pkg::core_ctrl_t   ctrl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    logic sync_dis;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) sync_dis <= 1'b0;
        else if (req_i.wr_en && req_i.addr == 4'h5) sync_dis <= req_i.wdata[4];
    end
    sequence s_rd0; req_i.rd_en && req_i.addr == 4'h0; endsequence
    sequence s_wr1; req_i.wr_en && req_i.addr == 4'h1; endsequence
    property p_synth; s_rd0 |=> rdata_o[7] == $past(status_i.synth_lock); endproperty
    property p_align; s_rd0 |=> rdata_o[6] == $past(status_i.align_lock); endproperty
    property p_id; s_rd0 |=> rvalid_o && rdata_o[5:0] == {1'b0, PART_CODE, REV_CODE}; endproperty
    property p_dly; s_wr1 |=> {ctrl_o.out_delay, ctrl_o.ptr_offset} == $past({req_i.wdata[7:6], req_i.wdata[2:0]});
    endproperty
    property p_fir; s_wr1 |=> {ctrl_o.filter_enable, ctrl_o.core_selftest_enable} == $past(req_i.wdata[4:3]);
    endproperty
    property p_load; status_i.sync_event && !sync_dis |=> ctrl_o.ptr_offset_load; endproperty
    property p_noload; !status_i.sync_event || sync_dis |=> !ctrl_o.ptr_offset_load; endproperty
    property p_rsvd; req_i.rd_en && req_i.addr == 4'hF |=> rdata_o == 8'h00; endproperty
    a_synth: assert property (p_synth) else $error("synth lock bit wrong");
    a_align: assert property (p_align) else $error("align lock bit wrong");
    a_id: assert property (p_id) else $error("part or revision code wrong");
    a_dly: assert property (p_dly) else $error("delay or offset not taken");
    a_fir: assert property (p_fir) else $error("filter or selftest not taken");
    a_load: assert property (p_load) else $error("offset reload missing");
    a_noload: assert property (p_noload) else $error("offset reload unexpected");
    a_rsvd: assert property (p_rsvd) else $error("spare register not zero");
endmodule
bind dac_control_register_bank dac_regs_props #(.PART_CODE(PART_CODE), .REV_CODE(REV_CODE)) u_props (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .req_i(req_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .status_i(status_i), .ctrl_o(ctrl_o));

// ===== host_model.sv
/* host model: one byte request per call, then an idle cycle.
   assumes the bank samples requests on the rising edge. */
module host_model (
    input wire logic               core_clk_i,
    output dac_regs_pkg::reg_req_t req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_o = '0;
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        req_o <= '{wr_en: wr, rd_en: !wr, addr: a, wdata: d};
        @(posedge core_clk_i);
        req_o <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

// ===== testbench.sv
/* testbench: register bank driven through the host model.
   assumes read data one cycle after the request. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                       clk = 1'b0;
    logic                       rstn_i = 1'b0;
    dac_regs_pkg::reg_req_t     req;
    logic [7:0]                 rdata;
    logic                       rvalid;
    dac_regs_pkg::core_status_t st = '0;
    dac_regs_pkg::core_ctrl_t   ctrl;
    logic [7:0]                 q[$];
    logic [7:0]                 v = 8'h30;
    int                         fails = 0;
    int                         n_compared = 0;
    int                         cyc = 0;
    always #4 clk = ~clk;
    host_model u_host (.core_clk_i(clk), .req_o(req));
    dac_control_register_bank #(.PART_CODE(3'h5), .REV_CODE(2'h0)) dut (.core_clk_i(clk), .rstn_i(rstn_i),
        .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .status_i(st), .ctrl_o(ctrl));
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic print_verdict();
        if (fails == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        q.push_back(e);
        u_host.xfer(1'b0, a, 8'h00);
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge clk) st <= st ^ m;
        @(posedge clk) st <= st ^ m;
        #1;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rvalid === 1'b1) check("rdata", rdata, q.pop_front());
        if (cyc > 3000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rstn_i <= 1'b1;
        #1 check("ctrl", ctrl, 8'h20);
        for (int i = 1; i < 16; i++) rd(i[3:0], dac_regs_pkg::RESET_VALUES[i]);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) st <= {k[1:0], 4'h0};
            rd(4'h0, {k[1:0], 1'b0, 3'h5, 2'h0});
        end
        u_host.xfer(1'b1, 4'h0, 8'hFF);
        u_host.xfer(1'b1, 4'hF, 8'hFF);
        rd(4'h0, {2'b11, 1'b0, 3'h5, 2'h0});
        rd(4'hF, 8'h00);
        for (int j = 0; j < 8; j++) begin
            v = lfsr(v);
            u_host.xfer(1'b1, 4'h1, {v[7:3], j[2:0]});
            rd(4'h1, {v[7:6], 1'b0, v[4:3], j[2:0]});
            check("ctrl", ctrl, {v[7:6], v[4:3], j[2:0], 1'b0});
        end
        @(posedge clk) rstn_i <= 1'b0;
        repeat (2) @(posedge clk);
        rstn_i <= 1'b1;
        #1 check("ctrl", ctrl, 8'h20);
        rd(4'h1, dac_regs_pkg::RESET_VALUES[1]);
        u_host.xfer(1'b1, 4'h1, 8'h01);
        for (int s = 0; s < 2; s++) begin
            u_host.xfer(1'b1, 4'h5, {3'h0, s[0], 4'h0});
            pulse(6'h08);
            check("load", {7'h0, ctrl.ptr_offset_load}, {7'h0, !s[0]});
        end
        pulse(6'h07);
        rd(4'h4, 8'h70);
        u_host.xfer(1'b1, 4'h4, 8'hFF);
        rd(4'h4, 8'h70);
        u_host.xfer(1'b1, 4'h4, 8'h00);
        rd(4'h4, 8'h00);
        repeat (4) @(posedge clk);
        check("pending", 8'(q.size()), 8'h00);
        print_verdict();
    end
endmodule
